// ===== rtl/vcmc_params.svh
// timing counts, field positions and reset values of the voice codec link
`ifndef VCMC_PARAMS_SVH
`define VCMC_PARAMS_SVH
// =============================================================
// clock and sampling rates
`define VCMC_CLK_HZ 100000000
`define VCMC_R0_HZ 4000
`define VCMC_R1_HZ 6400
`define VCMC_R2_HZ 8000
`define VCMC_R3_HZ 12800
`define VCMC_R4_HZ 16000
`define VCMC_R5_HZ 22050
`define VCMC_R6_HZ 32000
`define VCMC_R7_HZ 44100
`define VCMC_REC_MAX_RATE 3'h4
// =============================================================
// sample sync pulse width and host strobe timing
`define VCMC_SYNC_MIN_NS 15600
`define VCMC_SYNC_MAX_NS 125000
`define VCMC_SYNC_MIN_CYC ((`VCMC_SYNC_MIN_NS + 9) / 10)
`define VCMC_SYNC_MAX_CYC (`VCMC_SYNC_MAX_NS / 10)
`define VCMC_STB_MIN_NS 2000
`define VCMC_STB_MIN_CYC ((`VCMC_STB_MIN_NS + 9) / 10)
`define VCMC_CMD_GAP_NS 500
`define VCMC_CMD_GAP_CYC ((`VCMC_CMD_GAP_NS + 9) / 10)
`define VCMC_DAT_GAP_NS 200
`define VCMC_DAT_GAP_CYC ((`VCMC_DAT_GAP_NS + 9) / 10)
// =============================================================
// command byte and status byte fields
`define VCMC_OP_MSB 7
`define VCMC_OP_LSB 4
`define VCMC_ST_BUSY 0
`define VCMC_ST_ERR 1
`define VCMC_ST_FULL 2
`define VCMC_ST_EMPTY 3
`define VCMC_ST_BUS16 4
`define VCMC_ST_BYPASS 5
// =============================================================
// reset values and codec limits
`define VCMC_RST_WIDTH 4'h4
`define VCMC_RST_RATE 3'h2
`define VCMC_STEP_MIN 16'h0010
`define VCMC_STEP_MAX 16'h0800
`endif

// ===== rtl/vcmc_pkg.sv
// types shared by both ends of the voice codec link
package vcmc_pkg;
  // =============================================================
  // commands, methods and states
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_METHOD = 4'h1, OP_WIDTH = 4'h2, OP_BUS = 4'h3,
    OP_RATE = 4'h4, OP_BYPASS = 4'h5, OP_REC = 4'h8, OP_PLAY = 4'h9,
    OP_STOP = 4'hA
  } vcmc_op_t;
  typedef enum logic [2:0] {
    M_ADP4 = 3'h0, M_ENH = 3'h1, M_PCM8 = 3'h2, M_PCM16 = 3'h3,
    M_NLIN8 = 3'h4
  } vcmc_method_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_REC = 2'h1, S_PLAY = 2'h2
  } vcmc_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_STB = 2'h1, H_CAP = 2'h2
  } vcmc_hstate_t;
endpackage : vcmc_pkg

// ===== rtl/vcmc_link_if.sv
// parallel strobe bus and flag pins between host and codec
`timescale 1ns/1ps
interface vcmc_link_if;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic dc;
  logic [15:0] h_dout;
  logic h_oe_n;
  logic [15:0] d_dout;
  logic d_oe_n;
  logic [15:0] bus;
  logic busy_n;
  logic empty_flag;
  logic half_flag;
  logic buffer_full_flag;
  logic right_dma_request;
  // =============================================================
  // wire level: device wins while it drives, else the host's value
  assign bus = !d_oe_n ? d_dout : h_dout;
  modport dev (
    input cs_n, wr_n, rd_n, dc, bus,
    output d_dout, d_oe_n, busy_n, empty_flag, half_flag,
    output buffer_full_flag, right_dma_request
  );
  modport host (
    input bus, busy_n, empty_flag, half_flag, buffer_full_flag,
    input right_dma_request,
    output cs_n, wr_n, rd_n, dc, h_dout, h_oe_n
  );
endinterface : vcmc_link_if

// ===== rtl/vcmc_device.sv
// voice codec end: mode control, codec, two-entry buffer, sync flag
//
// Summary of operation
// RULE1 - no 16-bit PCM recording on 8-bit bus
// RULE2 - no 8-bit PCM recording on 16-bit bus
// RULE3 - host drains a full buffer within one sample
// RULE4 - host sends one command per setting
// RULE5 - host starts adaptive playback at phrase start
// RULE6 - standard adaptive: 4-bit code, step adapts each sample
// RULE7 - enhanced adaptive: code width four to eight
// RULE8 - enhanced 4-bit format differs from standard
// RULE9 - non-linear PCM expands finer near centre
// RULE10 - rates above 16 kHz are playback only
// RULE11 - bypass: one sync pulse per sample, bounded width
// RULE12 - host ends strobe 2 to 15 us after sync
// RULE13 - four method families including straight PCM
// RULE14 - half flag becomes sync when buffer bypassed
// RULE15 - full flag while buffer holds maximum words
// RULE16 - illegal record combination never starts recording
`timescale 1ns/1ps
`include "vcmc_params.svh"
module vcmc_device #(
  parameter int unsigned RATE_CYC [8] = '{
    `VCMC_CLK_HZ / `VCMC_R0_HZ, `VCMC_CLK_HZ / `VCMC_R1_HZ,
    `VCMC_CLK_HZ / `VCMC_R2_HZ, `VCMC_CLK_HZ / `VCMC_R3_HZ,
    `VCMC_CLK_HZ / `VCMC_R4_HZ, `VCMC_CLK_HZ / `VCMC_R5_HZ,
    `VCMC_CLK_HZ / `VCMC_R6_HZ, `VCMC_CLK_HZ / `VCMC_R7_HZ},
  parameter int unsigned SYNC_MAX_CYC = `VCMC_SYNC_MAX_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  vcmc_link_if.dev lnk,
  // converter side
  input wire logic [15:0] adc_sample,
  output logic [15:0] dac_sample,
  output logic dac_valid
);
  // =============================================================
  // codec arithmetic
  // predictor and step update shared by decoder and encoder
  function automatic logic [31:0] adapt(input vcmc_pkg::vcmc_method_t m,
      input logic [3:0] w, input logic [7:0] c, input logic [15:0] pr,
      input logic [15:0] st);
    logic signed [31:0] p, d, n, s;
    p = 32'(signed'(pr));
    s = 32'(st);
    if (m == vcmc_pkg::M_ADP4) begin
      // sign-magnitude code, step doubles on large codes  see RULE6
      d = (32'({c[2:0], 1'b1}) * s) >>> 3;
      if (c[3]) d = -d;
      if (c[2]) s = s <<< 1;
      else if (c[2:1] == 2'h0) s = s - (s >>> 3);
    end else begin
      // two's complement code of width w  see RULE7 see RULE8
      n = 32'(signed'(8'(c << (4'h8 - w))));
      d = (n * s) >>> 6;
      if (n >= 64 || n < -64) s = s + (s >>> 2);
      else if (n < 32 && n > -32) s = s - (s >>> 3);
    end
    p = p + d;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    if (s < 32'(`VCMC_STEP_MIN)) s = 32'(`VCMC_STEP_MIN);
    if (s > 32'(`VCMC_STEP_MAX)) s = 32'(`VCMC_STEP_MAX);
    return {p[15:0], s[15:0]};
  endfunction : adapt
  // quantise the prediction error of one input sample
  function automatic logic [7:0] encode(input vcmc_pkg::vcmc_method_t m,
      input logic [3:0] w, input logic [15:0] x, input logic [15:0] pr,
      input logic [15:0] st);
    logic signed [31:0] e, q;
    e = 32'(signed'(x)) - 32'(signed'(pr));
    if (m == vcmc_pkg::M_ADP4) begin
      q = ((e < 0 ? -e : e) <<< 2) / signed'(32'(st));
      if (q > 7) q = 7;
      return {4'h0, e < 0, q[2:0]};
    end
    q = (e <<< 6) / signed'(32'(st));
    if (q > 127) q = 127;
    if (q < -128) q = -128;
    return 8'(q[7:0] >>> (4'h8 - w)) & (8'hFF >> (4'h8 - w));
  endfunction : encode
  // expand one non-linear code, fine steps near zero  see RULE9
  function automatic logic [15:0] expand(input logic [7:0] c);
    logic [15:0] mag;
    mag = (({11'h000, 1'b1, c[3:0]} << c[6:4]) - 16'h0010) << 3;
    return c[7] ? 16'(-mag) : mag;
  endfunction : expand
  // =============================================================
  // state
  vcmc_pkg::vcmc_state_t st_q, st_d;
  vcmc_pkg::vcmc_method_t meth_q, meth_d;
  logic [3:0] width_q, width_d;
  logic bus16_q, bus16_d, bypass_q, bypass_d, err_q, err_d;
  logic [2:0] rate_q, rate_d;
  logic [15:0] pred_q, pred_d, step_q, step_d, cnt_q, cnt_d;
  logic [15:0] buf_q [2], buf_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] n_q, n_d;
  logic [15:0] dout_q, dout_d, dac_q, dac_d;
  logic doe_n_q, doe_n_d, dacv_q, dacv_d, busy_n_q, empty_q, half_q;
  logic full_q, dreq_q, wr, rd, tick, rec_ok, push, pop;
  logic [15:0] per, wid, word;
  logic [31:0] ad;
  logic [7:0] code;
  // =============================================================
  // next state
  always_comb begin
    st_d = st_q; meth_d = meth_q; width_d = width_q; bus16_d = bus16_q;
    bypass_d = bypass_q; rate_d = rate_q; err_d = err_q;
    pred_d = pred_q; step_d = step_q; cnt_d = cnt_q;
    buf_d = buf_q; wp_d = wp_q; rp_d = rp_q; n_d = n_q;
    dout_d = dout_q; doe_n_d = 1'b1; dac_d = dac_q; dacv_d = 1'b0;
    push = 1'b0; pop = 1'b0; word = 16'h0000; ad = 32'h0;
    wr = !lnk.cs_n && !lnk.wr_n;
    rd = !lnk.cs_n && !lnk.rd_n;
    per = 16'(RATE_CYC[rate_q]);
    // sync width is half the sample period, raised to the minimum, then cut to SYNC_MAX_CYC
    wid = per >> 1;
    if (wid < 16'(`VCMC_SYNC_MIN_CYC)) wid = 16'(`VCMC_SYNC_MIN_CYC);
    if (wid > 16'(SYNC_MAX_CYC)) wid = 16'(SYNC_MAX_CYC);
    tick = (st_q != vcmc_pkg::S_IDLE) && (cnt_q == 16'h0000);
    // legal record combinations only  see RULE1 see RULE2 see RULE10
    rec_ok = !(meth_q == vcmc_pkg::M_PCM16 && !bus16_q)
      && !(meth_q == vcmc_pkg::M_PCM8 && bus16_q)
      && (meth_q != vcmc_pkg::M_NLIN8)
      && (rate_q <= `VCMC_REC_MAX_RATE);
    code = encode(meth_q, width_q, adc_sample, pred_q, step_q);
    // status read clears the error flag; a new error in that cycle wins
    if (rd && !lnk.dc) err_d = 1'b0;
    // sample counter, free running while recording or playing
    if (st_q != vcmc_pkg::S_IDLE) cnt_d = tick ? per - 16'h1 : cnt_q - 16'h1;
    // settings are taken only while idle, one field per command
    if (wr && !lnk.dc) begin
      case (vcmc_pkg::vcmc_op_t'(lnk.bus[`VCMC_OP_MSB:`VCMC_OP_LSB]))
        vcmc_pkg::OP_METHOD: if (st_q == vcmc_pkg::S_IDLE
          && lnk.bus[2:0] <= 3'h4)
          meth_d = vcmc_pkg::vcmc_method_t'(lnk.bus[2:0]); // see RULE13
        vcmc_pkg::OP_WIDTH: if (st_q == vcmc_pkg::S_IDLE && lnk.bus[3:0] > 4'h3
          && lnk.bus[3:0] <= 4'h8) width_d = lnk.bus[3:0]; // see RULE7
        vcmc_pkg::OP_BUS: if (st_q == vcmc_pkg::S_IDLE) bus16_d = lnk.bus[0];
        vcmc_pkg::OP_RATE: if (st_q == vcmc_pkg::S_IDLE) rate_d = lnk.bus[2:0];
        vcmc_pkg::OP_BYPASS: if (st_q == vcmc_pkg::S_IDLE)
          bypass_d = lnk.bus[0];
        vcmc_pkg::OP_REC: if (st_q == vcmc_pkg::S_IDLE) begin
          // refused combination: stay idle and flag it  see RULE16
          if (rec_ok) begin
            st_d = vcmc_pkg::S_REC;
            cnt_d = per - 16'h0001;
          end else err_d = 1'b1;
        end
        vcmc_pkg::OP_PLAY: if (st_q == vcmc_pkg::S_IDLE) begin
          st_d = vcmc_pkg::S_PLAY;
          cnt_d = per - 16'h0001;
        end
        vcmc_pkg::OP_STOP: begin
          st_d = vcmc_pkg::S_IDLE;
          n_d = 2'h0; wp_d = 1'b0; rp_d = 1'b0; cnt_d = 16'h0000;
        end
        default: ;
      endcase
      // a new phrase restarts the adaptive state
      if (st_q == vcmc_pkg::S_IDLE) begin
        pred_d = 16'h0000;
        step_d = `VCMC_STEP_MIN;
      end
    end else if (st_q == vcmc_pkg::S_PLAY) begin
      // host data write; a write into a full buffer is an error
      if (wr && lnk.dc) begin
        if (n_q != 2'h2) push = 1'b1;
        else err_d = 1'b1;
        word = lnk.bus;
      end
      if (tick && n_q != 2'h0) begin
        pop = 1'b1;
        ad = adapt(meth_q, width_q, buf_q[rp_q][7:0], pred_q, step_q);
        dacv_d = 1'b1;
        case (meth_q)
          vcmc_pkg::M_PCM16: dac_d = buf_q[rp_q];
          vcmc_pkg::M_PCM8: dac_d = {buf_q[rp_q][7:0], 8'h00};
          vcmc_pkg::M_NLIN8: dac_d = expand(buf_q[rp_q][7:0]);
          default: begin
            dac_d = ad[31:16];
            pred_d = ad[31:16];
            step_d = ad[15:0];
          end
        endcase
      end else if (tick && !bypass_q) begin
        // buffer ran dry: playback ends by itself unless the buffer is bypassed
        st_d = vcmc_pkg::S_IDLE;
      end
    end else if (st_q == vcmc_pkg::S_REC) begin
      // host data read answers next cycle from the buffer head
      if (rd && lnk.dc && n_q != 2'h0) begin
        pop = 1'b1;
        dout_d = buf_q[rp_q];
        doe_n_d = 1'b0;
      end
      if (tick) begin
        ad = adapt(meth_q, width_q, code, pred_q, step_q);
        case (meth_q)
          vcmc_pkg::M_PCM16: word = adc_sample;
          vcmc_pkg::M_PCM8: word = {8'h00, adc_sample[15:8]};
          default: begin
            word = {8'h00, code};
            pred_d = ad[31:16];
            step_d = ad[15:0];
          end
        endcase
        // overrun when the host left the buffer full
        if (n_q != 2'h2 || pop) push = 1'b1;
        else err_d = 1'b1;
      end
    end
    if (rd && !lnk.dc) begin
      dout_d = 16'h0000;
      dout_d[`VCMC_ST_BUSY] = st_q != vcmc_pkg::S_IDLE;
      dout_d[`VCMC_ST_ERR] = err_q;
      dout_d[`VCMC_ST_FULL] = n_q == 2'h2;
      dout_d[`VCMC_ST_EMPTY] = n_q == 2'h0;
      dout_d[`VCMC_ST_BUS16] = bus16_q;
      dout_d[`VCMC_ST_BYPASS] = bypass_q;
      doe_n_d = 1'b0;
    end
    // two-entry buffer bookkeeping
    if (push) begin
      buf_d[wp_q] = word;
      wp_d = !wp_q;
    end
    if (pop) rp_d = !rp_q;
    n_d = (st_d == vcmc_pkg::S_IDLE && st_q != vcmc_pkg::S_IDLE)
      ? 2'h0 : 2'(n_q + {1'b0, push} - {1'b0, pop});
  end
  // =============================================================
  // registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= vcmc_pkg::S_IDLE; meth_q <= vcmc_pkg::M_ADP4;
      width_q <= `VCMC_RST_WIDTH; bus16_q <= 1'b0; bypass_q <= 1'b0;
      rate_q <= `VCMC_RST_RATE; err_q <= 1'b0; pred_q <= 16'h0000;
      step_q <= `VCMC_STEP_MIN; cnt_q <= 16'h0000;
      buf_q <= '{16'h0000, 16'h0000}; wp_q <= 1'b0; rp_q <= 1'b0;
      n_q <= 2'h0; dout_q <= 16'h0000; doe_n_q <= 1'b1;
      dac_q <= 16'h0000; dacv_q <= 1'b0; busy_n_q <= 1'b1;
      empty_q <= 1'b1; half_q <= 1'b0; full_q <= 1'b0; dreq_q <= 1'b0;
    end else begin
      st_q <= st_d; meth_q <= meth_d; width_q <= width_d;
      bus16_q <= bus16_d; bypass_q <= bypass_d; rate_q <= rate_d;
      err_q <= err_d; pred_q <= pred_d; step_q <= step_d; cnt_q <= cnt_d;
      buf_q <= buf_d; wp_q <= wp_d; rp_q <= rp_d; n_q <= n_d;
      dout_q <= dout_d; doe_n_q <= doe_n_d; dac_q <= dac_d;
      dacv_q <= dacv_d;
      busy_n_q <= st_d == vcmc_pkg::S_IDLE;
      empty_q <= n_d == 2'h0;
      full_q <= n_d == 2'h2; // see RULE15
      dreq_q <= n_d == 2'h2 && st_d == vcmc_pkg::S_REC;
      // bypassed: one pulse per sample at its start  see RULE14 see RULE11
      half_q <= bypass_d ? (st_d != vcmc_pkg::S_IDLE
        && cnt_d >= per - wid) : n_d != 2'h0;
    end
  end
  // =============================================================
  // outputs
  assign lnk.d_dout = dout_q;
  assign lnk.d_oe_n = doe_n_q;
  assign lnk.busy_n = busy_n_q;
  assign lnk.empty_flag = empty_q;
  assign lnk.half_flag = half_q;
  assign lnk.buffer_full_flag = full_q;
  assign lnk.right_dma_request = dreq_q;
  assign dac_sample = dac_q;
  assign dac_valid = dacv_q;
endmodule : vcmc_device

// ===== rtl/vcmc_host.sv
// host end: issues commands, moves voice words, keeps sync timing
`timescale 1ns/1ps
`include "vcmc_params.svh"
module vcmc_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  vcmc_link_if.host lnk,
  // command feed
  input wire logic cmd_valid,
  input wire logic [7:0] cmd,
  input wire logic phrase_start,
  output logic cmd_taken,
  // playback words in
  input wire logic pd_valid,
  input wire logic [15:0] pd_word,
  output logic pd_taken,
  // recorded words out
  output logic rd_valid,
  output logic [15:0] rd_word
);
  vcmc_pkg::vcmc_hstate_t hs_q, hs_d;
  vcmc_pkg::vcmc_state_t mode_q, mode_d;
  vcmc_pkg::vcmc_op_t op;
  logic bypass_q, bypass_d, half_q, cs_n_q, cs_n_d, wr_n_q, wr_n_d;
  logic rd_n_q, rd_n_d, dc_q, dc_d, oe_n_q, oe_n_d;
  logic ct_q, ct_d, pt_q, pt_d, rv_q, rv_d;
  logic [15:0] hd_q, hd_d, rw_q, rw_d;
  logic [7:0] gap_q, gap_d, scnt_q, scnt_d;
  logic sync_go;

  // =============================================================
  // next state
  always_comb begin
    hs_d = hs_q; mode_d = mode_q; bypass_d = bypass_q;
    cs_n_d = 1'b1; wr_n_d = 1'b1; rd_n_d = 1'b1; dc_d = dc_q;
    oe_n_d = 1'b1; hd_d = hd_q; ct_d = 1'b0; pt_d = 1'b0; rv_d = 1'b0;
    rw_d = rw_q; gap_d = gap_q; scnt_d = scnt_q;
    op = vcmc_pkg::vcmc_op_t'(cmd[`VCMC_OP_MSB:`VCMC_OP_LSB]);
    if (gap_q != 8'h00) gap_d = gap_q - 8'h01;
    // wait past the sync rise before ending the strobe  see RULE12
    if (lnk.half_flag && !half_q) scnt_d = 8'(`VCMC_STB_MIN_CYC);
    else if (scnt_q != 8'h00) scnt_d = scnt_q - 8'h01;
    sync_go = bypass_q && scnt_q == 8'h01;
    case (hs_q)
      vcmc_pkg::H_IDLE: if (gap_q == 8'h00) begin
        // one setting per command  see RULE4
        // adaptive playback only from a phrase start  see RULE5
        if (cmd_valid && (op != vcmc_pkg::OP_PLAY || phrase_start)) begin
          cs_n_d = 1'b0; wr_n_d = 1'b0; dc_d = 1'b0; oe_n_d = 1'b0;
          hd_d = {8'h00, cmd}; ct_d = 1'b1;
          gap_d = 8'(`VCMC_CMD_GAP_CYC);
          hs_d = vcmc_pkg::H_STB;
          if (op == vcmc_pkg::OP_REC) mode_d = vcmc_pkg::S_REC;
          if (op == vcmc_pkg::OP_PLAY) mode_d = vcmc_pkg::S_PLAY;
          if (op == vcmc_pkg::OP_STOP) mode_d = vcmc_pkg::S_IDLE;
          if (op == vcmc_pkg::OP_BYPASS) bypass_d = cmd[0];
        end else if (mode_q == vcmc_pkg::S_PLAY && pd_valid
            && (bypass_q ? sync_go : !lnk.buffer_full_flag)) begin
          cs_n_d = 1'b0; wr_n_d = 1'b0; dc_d = 1'b1; oe_n_d = 1'b0;
          hd_d = pd_word; pt_d = 1'b1;
          gap_d = 8'(`VCMC_DAT_GAP_CYC);
          hs_d = vcmc_pkg::H_STB;
        end else if (mode_q == vcmc_pkg::S_REC
            && (bypass_q ? sync_go : !lnk.empty_flag)) begin
          // drain back to back once words wait, once per sync pulse when bypassed  see RULE3
          cs_n_d = 1'b0; rd_n_d = 1'b0; dc_d = 1'b1;
          hs_d = vcmc_pkg::H_STB;
        end
      end
      vcmc_pkg::H_STB: hs_d = rd_n_q ? vcmc_pkg::H_IDLE : vcmc_pkg::H_CAP;
      vcmc_pkg::H_CAP: begin
        rw_d = lnk.bus;
        rv_d = 1'b1;
        hs_d = vcmc_pkg::H_IDLE;
      end
      default: hs_d = vcmc_pkg::H_IDLE;
    endcase
  end

  // =============================================================
  // registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hs_q <= vcmc_pkg::H_IDLE; mode_q <= vcmc_pkg::S_IDLE;
      bypass_q <= 1'b0; half_q <= 1'b0; cs_n_q <= 1'b1; wr_n_q <= 1'b1;
      rd_n_q <= 1'b1; dc_q <= 1'b0; oe_n_q <= 1'b1; hd_q <= 16'h0000;
      ct_q <= 1'b0; pt_q <= 1'b0; rv_q <= 1'b0; rw_q <= 16'h0000;
      gap_q <= 8'h00; scnt_q <= 8'h00;
    end else begin
      hs_q <= hs_d; mode_q <= mode_d; bypass_q <= bypass_d;
      half_q <= lnk.half_flag; cs_n_q <= cs_n_d; wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d; dc_q <= dc_d; oe_n_q <= oe_n_d; hd_q <= hd_d;
      ct_q <= ct_d; pt_q <= pt_d; rv_q <= rv_d; rw_q <= rw_d;
      gap_q <= gap_d; scnt_q <= scnt_d;
    end
  end

  // =============================================================
  // outputs
  assign lnk.cs_n = cs_n_q;
  assign lnk.wr_n = wr_n_q;
  assign lnk.rd_n = rd_n_q;
  assign lnk.dc = dc_q;
  assign lnk.h_dout = hd_q;
  assign lnk.h_oe_n = oe_n_q;
  assign cmd_taken = ct_q;
  assign pd_taken = pt_q;
  assign rd_valid = rv_q;
  assign rd_word = rw_q;
endmodule : vcmc_host

// ===== dv/vcmc_link_assertions.sv
// concurrent checks on the link between host and codec ends
`timescale 1ns/1ps
module vcmc_link_assertions #(
  parameter int SYNC_CYC = 300
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // strobes and bus
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic dc,
  input wire logic h_oe_n,
  input wire logic d_oe_n,
  input wire logic [15:0] bus,
  // flags
  input wire logic busy_n,
  input wire logic empty_flag,
  input wire logic half_flag,
  input wire logic buffer_full_flag,
  input wire logic right_dma_request
);
  // =============================================================
  // settings mirrored from command writes
  logic [2:0] meth_q, meth_d, rate_q, rate_d;
  logic bus16_q, bus16_d, byp_q, byp_d;
  logic [13:0] hi_q, hi_d, sr_q, sr_d;
  logic cmd_wr, rec_wr, bad_rec;
  assign cmd_wr = !cs_n && !wr_n && !dc;
  assign rec_wr = cmd_wr && busy_n && bus[7:4] == 4'h8;
  assign bad_rec = (meth_q == 3'h3 && !bus16_q) || meth_q == 3'h4
    || (meth_q == 3'h2 && bus16_q) || rate_q > 3'h4;
  // settings only count while idle, the device drops them otherwise
  always_comb begin
    {meth_d, rate_d, bus16_d, byp_d} = {meth_q, rate_q, bus16_q, byp_q};
    if (cmd_wr && busy_n) begin
      case (bus[7:4])
        4'h1: meth_d = bus[2:0];
        4'h3: bus16_d = bus[0];
        4'h4: rate_d = bus[2:0];
        4'h5: byp_d = bus[0];
        default: ;
      endcase
    end
    hi_d = half_flag ? hi_q + 14'h1 : 14'h0;
    // saturates so a long idle spell never wraps into the window
    sr_d = (half_flag && hi_q == 14'h0) ? 14'h1
      : sr_q + 14'(sr_q != 14'h3FFF);
  end
  // registers of the mirror and the sync counters
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {meth_q, rate_q, bus16_q, byp_q} <= 8'h08;
      {hi_q, sr_q} <= {14'h0, 14'h3FFF};
    end else begin
      {meth_q, rate_q, bus16_q, byp_q} <= {meth_d, rate_d, bus16_d, byp_d};
      {hi_q, sr_q} <= {hi_d, sr_d};
    end
  end
  // =============================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  read_answer_a: assert property (!cs_n && !rd_n && dc && !empty_flag
    |=> !d_oe_n) else $error("data read not answered");
  answer_cause_a: assert property (!d_oe_n |-> !$past(rd_n)
    && !$past(cs_n) && h_oe_n) else $error("answer without read");
  full_flag_a: assert property (buffer_full_flag |-> !empty_flag)
    else $error("full and empty together");
  dma_request_a: assert property (right_dma_request |->
    buffer_full_flag && !busy_n) else $error("request while not full");
  rec_refused_a: assert property (
    rec_wr && bad_rec |=> busy_n [*8]) else $error("illegal record began");
  rec_start_a: assert property (
    rec_wr && !bad_rec |-> ##[1:2] !busy_n)
    else $error("legal record did not begin");
  sync_width_a: assert property ($fell(half_flag) && byp_q
    |-> hi_q <= 14'(SYNC_CYC)) else $error("sync pulse too long");
  strobe_window_a: assert property (byp_q && !cs_n && dc
    && !(rd_n && wr_n) |-> sr_q >= 14'd199 && sr_q <= 14'd1500)
    else $error("data strobe outside sync window");
  // main scenarios
  cover property (rec_wr && bad_rec);
  cover property (rec_wr && !bad_rec);
  cover property ($fell(half_flag) && byp_q);
  cover property (right_dma_request && !busy_n);
endmodule : vcmc_link_assertions

// ===== dv/voice_codec_mode_control_bench.sv
// self-checking bench: host and codec ends joined across the link
`timescale 1ns/1ps
module voice_codec_mode_control_bench;
  localparam int SYNC_W = 300;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0, phrase_start = 1'b0, pd_valid = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [15:0] pd_word = 16'h0000, adc_sample = 16'hA5C3;
  logic cmd_taken, pd_taken, rd_valid, dac_valid, seen;
  logic [15:0] rd_word, dac_sample;
  int num_errors = 0, checks = 0, n, hi, lo;
  // rows: method, bus width, rate index, record accepted
  logic [15:0] rows [9] = '{16'h0041, 16'h1121, 16'h3020, 16'h3121,
    16'h2120, 16'h2021, 16'h4020, 16'h0050, 16'h0070};
  // =============================================================
  // the two ends, the link and the checker
  vcmc_link_if lnk ();
  vcmc_device #(.RATE_CYC('{8{400}}), .SYNC_MAX_CYC(SYNC_W)) i_vcmc_device (
    .ref_clk(ref_clk), .reset(reset), .lnk(lnk.dev),
    .adc_sample(adc_sample), .dac_sample(dac_sample), .dac_valid(dac_valid));
  vcmc_host i_vcmc_host (.ref_clk(ref_clk), .reset(reset), .lnk(lnk.host),
    .cmd_valid(cmd_valid), .cmd(cmd), .phrase_start(phrase_start),
    .cmd_taken(cmd_taken), .pd_valid(pd_valid), .pd_word(pd_word),
    .pd_taken(pd_taken), .rd_valid(rd_valid), .rd_word(rd_word));
  vcmc_link_assertions #(.SYNC_CYC(SYNC_W)) i_vcmc_link_assertions (
    .ref_clk(ref_clk), .reset(reset), .cs_n(lnk.cs_n), .wr_n(lnk.wr_n),
    .rd_n(lnk.rd_n), .dc(lnk.dc), .h_oe_n(lnk.h_oe_n), .d_oe_n(lnk.d_oe_n),
    .bus(lnk.bus), .busy_n(lnk.busy_n), .empty_flag(lnk.empty_flag),
    .half_flag(lnk.half_flag), .buffer_full_flag(lnk.buffer_full_flag),
    .right_dma_request(lnk.right_dma_request));
  always #5 ref_clk = ~ref_clk;
  // =============================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one command byte or voice word, held until the host takes it
  task automatic give(input bit data, input logic [15:0] w);
    int k;
    k = 0;
    @(posedge ref_clk);
    if (data) begin
      pd_valid <= 1'b1;
      pd_word <= w;
    end else begin
      cmd_valid <= 1'b1;
      cmd <= w[7:0];
    end
    do begin
      @(posedge ref_clk);
      k++;
    end while ((data ? pd_taken : cmd_taken) !== 1'b1 && k < 300);
    cmd_valid <= 1'b0;
    pd_valid <= 1'b0;
    chk(16'(k < 300), 16'h1);
  endtask : give
  // bounded wait for a played or a recorded word
  task automatic catch(input bit dac, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while ((dac ? dac_valid : rd_valid) !== 1'b1 && k < lim);
    chk(16'(k < lim), 16'h1);
  endtask : catch
  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // =============================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(16'({lnk.busy_n, lnk.empty_flag, lnk.half_flag, lnk.cs_n,
      lnk.buffer_full_flag, lnk.right_dma_request, lnk.d_oe_n}), 16'h0069);
    give(0, 16'h0026);
    foreach (rows[i]) begin
      give(0, 16'({4'h1, rows[i][15:12]}));
      give(0, 16'({4'h3, rows[i][11:8]}));
      give(0, 16'({4'h4, rows[i][7:4]}));
      give(0, 16'h0080);
      repeat (3) @(posedge ref_clk);
      chk(16'(lnk.busy_n), 16'(!rows[i][0]));
      if (rows[i][0]) catch(0, 2000);
      if (rows[i][15:8] == 8'h31) chk(rd_word, adc_sample);
      give(0, 16'h00A0);
      repeat (3) @(posedge ref_clk);
      chk(16'({lnk.busy_n, lnk.empty_flag}), 16'h3);
    end
    // playback is held back until the phrase boundary is flagged
    give(0, 16'h0013);
    give(0, 16'h0031);
    @(posedge ref_clk);
    cmd <= 8'h90;
    cmd_valid <= 1'b1;
    seen = 1'b0;
    repeat (100) begin
      @(posedge ref_clk);
      seen = seen | cmd_taken;
    end
    chk(16'(seen), 16'h0);
    phrase_start <= 1'b1;
    give(0, 16'h0090);
    give(1, 16'h1234);
    give(1, 16'hBEEF);
    repeat (3) @(posedge ref_clk);
    chk(16'(lnk.buffer_full_flag), 16'h1);
    catch(1, 1000);
    chk(dac_sample, 16'h1234);
    catch(1, 1000);
    chk(dac_sample, 16'hBEEF);
    repeat (500) @(posedge ref_clk);
    chk(16'(lnk.busy_n), 16'h1);
    // bypass recording: one sync pulse of clamped width per sample
    give(0, 16'h0012);
    give(0, 16'h0030);
    give(0, 16'h0042);
    // commands back to back keep the host off the bus, so the buffer fills
    give(0, 16'h0080);
    repeat (18) give(0, 16'h0000);
    chk(16'(lnk.right_dma_request), 16'h1);
    chk(16'(lnk.buffer_full_flag), 16'h1);
    give(0, 16'h00A0);
    give(0, 16'h0051);
    give(0, 16'h0080);
    for (n = 0; lnk.half_flag !== 1'b1 && n < 1000; n++) @(posedge ref_clk);
    for (hi = 0; lnk.half_flag === 1'b1 && hi < 1000; hi++) @(posedge ref_clk);
    for (lo = 0; lnk.half_flag !== 1'b1 && lo < 1000; lo++) @(posedge ref_clk);
    chk(16'(hi), 16'(SYNC_W));
    chk(16'(hi + lo), 16'h0190);
    catch(0, 1000);
    chk(rd_word, {8'h00, adc_sample[15:8]});
    give(0, 16'h00A0);
    print_verdict();
  end
  // watchdog: the whole run needs well under this span
  initial begin
    #900000;
    num_errors++;
    print_verdict();
  end
endmodule : voice_codec_mode_control_bench
